// ### amx_pkg.sv
// shared constants for the converter input multiplexer control
package amx_pkg;

  // ----------------------------------------------------------------
  // register map (special function register port addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAIR_CFG    = 8'hBA;
  localparam logic [7:0] ADDR_CHAN_SEL    = 8'hBB;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         PAIR_BITS        = 4;
  localparam int         CODE_BITS        = 4;
  localparam logic [3:0] PAIR_CFG_RESET   = 4'h0;
  localparam logic [3:0] CHAN_SEL_RESET   = 4'h0;
  localparam logic [3:0] UNUSED_READ      = 4'h0;

  // ----------------------------------------------------------------
  // converter timing
  // ----------------------------------------------------------------
  localparam int         RESULT_BITS      = 10;
  localparam int         LP_TRACK_CLOCKS  = 3;
  localparam int         SAR_DIV_BITS     = 5;

  typedef enum logic [1:0] {
    MEAS_SINGLE,
    MEAS_DIFF_POS,
    MEAS_DIFF_NEG
  } amx_meas_t;

endpackage

// ### amx_mux_ctrl.sv
// input pairing, channel selection and conversion sequencing control
`timescale 1ns/10ps

// How it works
// - in low-power track mode, track three SAR clocks before approximation.
// - pair config bits 0..3 make pairs 0/1..6/7 differential when set.
// - channel select bits 7..4 read zero and ignore writes.
// - channel select bits 3..0 hold a 4-bit mux address, all codes valid.
// - results are RESULT_W bits wide, 10 by default.
// - paired even code measures even minus odd; odd code reverses it.
// - differential results are two's complement, single-ended unsigned.
module amx_mux_ctrl #(
  parameter int RESULT_W = amx_pkg::RESULT_BITS
) (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                srst_i,
  // special function register port
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic [7:0]          sfr_wdata_i,
  input  wire logic                sfr_wr_i,
  output logic      [7:0]          sfr_rdata_o,
  // conversion control
  input  wire logic                low_power_track_select_i,
  input  wire logic [4:0]          sar_div_i,
  input  wire logic                conv_start_i,
  output logic                     conv_busy_o,
  output logic                     tracking_o,
  output logic                     sar_clk_tick_o,
  // raw result from the approximation core
  input  wire logic                sar_done_i,
  input  wire logic [RESULT_W-1:0] sar_result_i,
  // analog mux steering and result outputs
  output logic      [2:0]          mux_pos_sel_o,
  output logic      [2:0]          mux_neg_sel_o,
  output logic                     mux_neg_is_gnd_o,
  output logic                     result_signed_o,
  output logic                     result_valid_o,
  output logic      [RESULT_W-1:0] result_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0] pair_cfg_reg;
  logic [3:0] pair_cfg_next;
  logic [3:0] chan_code_reg;
  logic [3:0] chan_code_next;

  always_comb begin
    pair_cfg_next  = pair_cfg_reg;
    chan_code_next = chan_code_reg;
    if (sfr_wr_i) begin
      if (sfr_addr_i == amx_pkg::ADDR_PAIR_CFG) begin
        pair_cfg_next = sfr_wdata_i[3:0];
      end
      if (sfr_addr_i == amx_pkg::ADDR_CHAN_SEL) begin
        chan_code_next = sfr_wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pair_cfg_reg  <= amx_pkg::PAIR_CFG_RESET;
      chan_code_reg <= amx_pkg::CHAN_SEL_RESET;
    end else begin
      pair_cfg_reg  <= pair_cfg_next;
      chan_code_reg <= chan_code_next;
    end
  end

  // unused upper bits always read back as zero
  function automatic logic [7:0] read_word(input logic [3:0] field);
    read_word = {amx_pkg::UNUSED_READ, field};
  endfunction

  always_comb begin
    sfr_rdata_o = 8'h00;
    unique case (sfr_addr_i)
      amx_pkg::ADDR_PAIR_CFG: sfr_rdata_o = read_word(pair_cfg_reg);
      amx_pkg::ADDR_CHAN_SEL: sfr_rdata_o = read_word(chan_code_reg);
      default:                sfr_rdata_o = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // channel decode
  // ----------------------------------------------------------------
  function automatic amx_pkg::amx_meas_t meas_of(input logic [3:0] code,
                                                 input logic [3:0] pairs);
    if (code[3] || !pairs[code[2:1]]) begin
      meas_of = amx_pkg::MEAS_SINGLE;
    end else if (code[0]) begin
      meas_of = amx_pkg::MEAS_DIFF_NEG;
    end else begin
      meas_of = amx_pkg::MEAS_DIFF_POS;
    end
  endfunction

  amx_pkg::amx_meas_t meas;
  assign meas = meas_of(chan_code_reg, pair_cfg_reg);

  always_comb begin
    mux_pos_sel_o    = chan_code_reg[2:0];
    mux_neg_sel_o    = chan_code_reg[2:0] ^ 3'h1;
    mux_neg_is_gnd_o = (meas == amx_pkg::MEAS_SINGLE);
  end

  // ----------------------------------------------------------------
  // SAR clock divider
  // ----------------------------------------------------------------
  logic [4:0] div_cnt_reg;
  logic [4:0] div_cnt_next;
  logic       tick;
  logic       start_take;

  assign start_take = conv_start_i && !conv_busy_o;

  // restart on a taken start so the first track period is whole
  always_comb begin
    tick         = (div_cnt_reg >= sar_div_i);
    div_cnt_next = tick ? 5'h00 : div_cnt_reg + 5'h01;
    if (start_take) begin
      div_cnt_next = 5'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_cnt_reg <= 5'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  assign sar_clk_tick_o = tick;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } amx_state_t;

  amx_state_t          state_reg;
  amx_state_t          state_next;
  logic [1:0]          trk_cnt_reg;
  logic [1:0]          trk_cnt_next;
  logic                sign_reg;
  logic                sign_next;
  logic                valid_reg;
  logic                valid_next;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] result_next;

  always_comb begin
    state_next   = state_reg;
    trk_cnt_next = trk_cnt_reg;
    sign_next    = sign_reg;
    valid_next   = 1'b0;
    result_next  = result_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (conv_start_i) begin
          sign_next    = (meas != amx_pkg::MEAS_SINGLE);
          trk_cnt_next = 2'h0;
          state_next   = low_power_track_select_i ? ST_TRACK
                                                  : ST_CONVERT;
        end
      end
      ST_TRACK: begin
        if (tick) begin
          if (trk_cnt_reg ==
              2'(amx_pkg::LP_TRACK_CLOCKS - 1)) begin
            state_next = ST_CONVERT;
          end else begin
            trk_cnt_next = trk_cnt_reg + 2'h1;
          end
        end
      end
      ST_CONVERT: begin
        if (sar_done_i) begin
          result_next = sar_result_i;
          valid_next  = 1'b1;
          state_next  = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg   <= ST_IDLE;
      trk_cnt_reg <= 2'h0;
      sign_reg    <= 1'b0;
      valid_reg   <= 1'b0;
      result_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      trk_cnt_reg <= trk_cnt_next;
      sign_reg    <= sign_next;
      valid_reg   <= valid_next;
      result_reg  <= result_next;
    end
  end

  // ----------------------------------------------------------------
  // status and result outputs
  // ----------------------------------------------------------------

  assign conv_busy_o     = (state_reg != ST_IDLE);
  assign tracking_o      = (state_reg == ST_TRACK) ||
                           (state_reg == ST_IDLE &&
                            !low_power_track_select_i);
  assign result_signed_o = sign_reg;
  assign result_valid_o  = valid_reg;
  assign result_o        = result_reg;

endmodule

// ### amx_mux_ctrl_monitor.sv
// concurrent checks on the mux control ports
`timescale 1ns/10ps
module amx_mux_ctrl_monitor #(
  parameter int RESULT_W = amx_pkg::RESULT_BITS
) (
  input wire logic                clock_i,
  input wire logic                srst_i,
  input wire logic [7:0]          sfr_addr_i,
  input wire logic [7:0]          sfr_wdata_i,
  input wire logic                sfr_wr_i,
  input wire logic [7:0]          sfr_rdata_o,
  input wire logic                low_power_track_select_i,
  input wire logic                conv_busy_o,
  input wire logic                tracking_o,
  input wire logic                sar_done_i,
  input wire logic [RESULT_W-1:0] sar_result_i,
  input wire logic [2:0]          mux_pos_sel_o,
  input wire logic [2:0]          mux_neg_sel_o,
  input wire logic                mux_neg_is_gnd_o,
  input wire logic                result_signed_o,
  input wire logic                result_valid_o,
  input wire logic [RESULT_W-1:0] result_o
);
  localparam logic [7:0] A = amx_pkg::ADDR_PAIR_CFG;
  localparam logic [7:0] C = amx_pkg::ADDR_CHAN_SEL;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_RD_HI: assert property (sfr_rdata_o[7:4] == 4'h0)
    else $error("upper bits read nonzero");
  AST_WR: assert property (sfr_wr_i && sfr_addr_i == C |=>
    sfr_addr_i != C || sfr_rdata_o[3:0] == $past(sfr_wdata_i[3:0]))
    else $error("channel code not stored");
  AST_POS: assert property (sfr_addr_i == C |->
    mux_pos_sel_o == sfr_rdata_o[2:0]) else $error("bad positive input");
  AST_NEG: assert property (mux_neg_sel_o == (mux_pos_sel_o ^ 3'h1))
    else $error("bad negative input");
  AST_HI: assert property (sfr_addr_i == C && sfr_rdata_o[3] |->
    mux_neg_is_gnd_o) else $error("upper code not single ended");
  AST_PAIR: assert property (sfr_addr_i == A &&
    !sfr_rdata_o[mux_pos_sel_o[2:1]] |-> mux_neg_is_gnd_o)
    else $error("unpaired input not single ended");
  AST_TRK: assert property ($rose(conv_busy_o) &&
    low_power_track_select_i |-> tracking_o [*3])
    else $error("low power track too short");
  AST_VAL: assert property (result_valid_o |-> $past(sar_done_i) &&
    result_o == $past(sar_result_i)) else $error("bad result");
  AST_SGN: assert property ($rose(conv_busy_o) |->
    result_signed_o == !$past(mux_neg_is_gnd_o)) else $error("bad sign");
  cover property (result_valid_o && result_signed_o);
  cover property (result_valid_o && !result_signed_o);
  cover property ($rose(conv_busy_o) && low_power_track_select_i);
endmodule
bind amx_mux_ctrl amx_mux_ctrl_monitor #(.RESULT_W(RESULT_W)) mon (
  .clock_i(clock_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o),
  .low_power_track_select_i(low_power_track_select_i),
  .conv_busy_o(conv_busy_o), .tracking_o(tracking_o),
  .sar_done_i(sar_done_i), .sar_result_i(sar_result_i),
  .mux_pos_sel_o(mux_pos_sel_o), .mux_neg_sel_o(mux_neg_sel_o),
  .mux_neg_is_gnd_o(mux_neg_is_gnd_o), .result_signed_o(result_signed_o),
  .result_valid_o(result_valid_o), .result_o(result_o));

// ### tb_top.sv
// self-checking bench for the mux control
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] A = amx_pkg::ADDR_PAIR_CFG;
  localparam logic [7:0] C = amx_pkg::ADDR_CHAN_SEL;
  logic clock_i = 0, srst_i = 1, sfr_wr_i = 0, lp = 0, start = 0, done = 0;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, rdata;
  logic [9:0] res_in = 0, result_o;
  logic busy, trk, tick, gnd, sgn, valid;
  logic [2:0] pos, neg;
  logic [4:0] div = 5'h00;
  int n_mismatch = 0, checks = 0;
  always #5 clock_i = ~clock_i;
  amx_mux_ctrl amx_mux_ctrl_inst (.clock_i(clock_i), .srst_i(srst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rdata_o(rdata), .low_power_track_select_i(lp), .sar_div_i(div),
    .conv_start_i(start), .conv_busy_o(busy), .tracking_o(trk),
    .sar_clk_tick_o(tick), .sar_done_i(done), .sar_result_i(res_in),
    .mux_pos_sel_o(pos), .mux_neg_sel_o(neg), .mux_neg_is_gnd_o(gnd),
    .result_signed_o(sgn), .result_valid_o(valid), .result_o(result_o));
  task chk(string n, logic [9:0] e, logic [9:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock_i); sfr_addr_i = a; sfr_wdata_i = d; sfr_wr_i = 1;
    @(negedge clock_i); sfr_wr_i = 0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e, string n);
    @(negedge clock_i); sfr_addr_i = a;
    #1 chk(n, e, rdata);
  endtask
  task t_regs();
    rd(A, 8'h00, "pair_rst");
    rd(C, 8'h00, "chan_rst");
    wr(C, 8'hF5); rd(C, 8'h05, "chan");
    wr(A, 8'hFA); rd(A, 8'h0A, "pair");
    wr(8'hBC, 8'h33); rd(8'hBC, 8'h00, "unmapped");
  endtask
  task t_route();
    for (int p = 0; p < 16; p += 5) begin
      wr(A, p[7:0]);
      for (int c = 0; c < 16; c++) begin
        wr(C, c[7:0]);
        #1 chk("pos", c[2:0], pos);
        chk("neg", c[2:0] ^ 3'h1, neg);
        chk("gnd", c[3] | !p[c[2:1]], gnd);
      end
    end
  endtask
  task t_conv(logic m, logic [4:0] d, logic [9:0] r, logic s);
    int k, nt, et, en;
    div = d; lp = m; start = 1;
    @(negedge clock_i); start = 0;
    chk("busy", 1, busy);
    k = 0; nt = 0;
    et = m ? amx_pkg::LP_TRACK_CLOCKS * (d + 1) : 0;
    en = m ? amx_pkg::LP_TRACK_CLOCKS : 0;
    while (trk === 1'b1 && k < 50) begin
      k++;
      nt += (tick === 1'b1);
      @(negedge clock_i);
    end
    chk("track", 10'(et), 10'(k));
    chk("ticks", 10'(en), 10'(nt));
    if (k == 50) results();
    res_in = r; done = 1;
    @(negedge clock_i); done = 0;
    chk("valid", 1, valid);
    chk("result", r, result_o);
    chk("signed", s, sgn);
    @(negedge clock_i);
    chk("pulse", 0, valid);
  endtask
  task t_rst();
    wr(A, 8'h0F); wr(C, 8'h07);
    lp = 1; start = 1;
    @(negedge clock_i); start = 0; srst_i = 1;
    chk("busy_pre", 1, busy);
    @(negedge clock_i); srst_i = 0;
    chk("busy_rst", 0, busy);
    chk("trk_rst", 0, trk);
    chk("res_rst", 0, result_o);
    rd(A, 8'h00, "pair_rst2");
    rd(C, 8'h00, "chan_rst2");
  endtask
  initial begin
    repeat (4) @(negedge clock_i);
    srst_i = 0;
    t_regs();
    t_route();
    wr(A, 8'h01); wr(C, 8'h00);
    t_conv(1, 5'h00, 10'h3FF, 1);
    wr(C, 8'h09);
    t_conv(0, 5'h00, 10'h200, 0);
    wr(C, 8'h01);
    t_conv(1, 5'h02, 10'h155, 1);
    t_rst();
    results();
  end
endmodule
